// file: xgr_pkg.sv
// Contract
// - Independent 32-bit transmit and receive paths
// - Full-duplex operation only
// - Characters driven and sampled on direction clock
// - A character on every clock, no gaps
// - Monitor receive path for link fault reports
// - Single fixed ten gigabit line rate; the model moves one 32-bit word per 64 ns link clock
// - Each direction: data, control and clock
// - Four byte lanes sharing one clock
// - Octets fill lanes round-robin from lane 0
// - Delimiters and idles flagged as control
// - Same behaviour toward extender as physical layer
// - Behaves as if parallel interface present
// - Octet requests fill lanes low to high
// - Start, six preambles, then frame delimiter
// - Complete maps to Terminate, then gap
// - Start plus eight octets nulled; no Terminate octet
package xgr_pkg;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 4;
    localparam int LANES  = 4;
    localparam int LANE_W = 8;
    localparam int LINK_W = DATA_W + CTRL_W + 1;

    localparam logic [7:0] CH_IDLE  = 8'h07;
    localparam logic [7:0] CH_START = 8'hFB;
    localparam logic [7:0] CH_TERM  = 8'hFD;
    localparam logic [7:0] CH_ERR   = 8'hFE;
    localparam logic [7:0] CH_SEQ   = 8'h9C;
    localparam logic [7:0] CH_PRE   = 8'h55;
    localparam logic [7:0] CH_SFD   = 8'hD5;
    localparam logic [7:0] LF_CODE  = 8'h01;
    localparam logic [7:0] NULL_OCT = 8'h00;

    localparam logic [31:0] IDLE_WORD = {4{CH_IDLE}};
    localparam logic [3:0]  IDLE_CTRL = 4'hF;
    localparam logic [3:0]  SEQ_CTRL  = 4'h1;

    localparam int SYS_PERIOD_NS  = 4;
    localparam int LINK_PERIOD_NS = 64;
    localparam int LINK_DIV       = LINK_PERIOD_NS / SYS_PERIOD_NS;

    localparam int PRE_OCTETS    = 7;
    localparam int NULL_OCTETS   = 8;
    localparam int IPG_WORDS     = 3;
    localparam int LF_HOLD_WORDS = 128;

    typedef enum logic [2:0] {
        XGR_TX_IDLE = 3'h1,
        XGR_TX_DATA = 3'h2,
        XGR_TX_IPG  = 3'h4
    } xgr_tx_state_e;

    typedef enum logic [1:0] {
        XGR_RX_IDLE  = 2'h1,
        XGR_RX_FRAME = 2'h2
    } xgr_rx_state_e;
endpackage

// file: xgr_if.sv
interface xgr_if;
    logic                        tx_clk;
    logic [xgr_pkg::DATA_W-1:0]  txd;
    logic [xgr_pkg::CTRL_W-1:0]  txc;
    logic                        rx_clk;
    logic [xgr_pkg::DATA_W-1:0]  rxd;
    logic [xgr_pkg::CTRL_W-1:0]  rxc;

    modport rs (
        output tx_clk,
        output txd,
        output txc,
        input  rx_clk,
        input  rxd,
        input  rxc
    );

    modport phy (
        input  tx_clk,
        input  txd,
        input  txc,
        output rx_clk,
        output rxd,
        output rxc
    );
endinterface

// file: xgr_sync.sv
module xgr_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// file: xgr_phy.sv
module xgr_phy #(
    parameter int DIV = xgr_pkg::LINK_DIV
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    xgr_if.phy                              link,
    output logic                            tx_word_valid,
    output logic [xgr_pkg::DATA_W-1:0]      tx_word,
    output logic [xgr_pkg::CTRL_W-1:0]      tx_word_ctrl,
    input  wire logic                       rx_word_valid,
    input  wire logic [xgr_pkg::DATA_W-1:0] rx_word,
    input  wire logic [xgr_pkg::CTRL_W-1:0] rx_word_ctrl,
    output logic                            rx_word_ready
);
    localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
    localparam logic [7:0] DIV_HALF = 8'(DIV / 2);

    logic [xgr_pkg::LINK_W-1:0] tx_s;
    logic                       tclk_prev;
    logic                       next_tclk_prev;
    logic                       next_tx_word_valid;
    logic [xgr_pkg::DATA_W-1:0] next_tx_word;
    logic [xgr_pkg::CTRL_W-1:0] next_tx_word_ctrl;
    logic [7:0]                 div;
    logic [7:0]                 next_div;
    logic                       rclk;
    logic                       next_rclk;
    logic [xgr_pkg::DATA_W-1:0] rxd_q;
    logic [xgr_pkg::DATA_W-1:0] next_rxd;
    logic [xgr_pkg::CTRL_W-1:0] rxc_q;
    logic [xgr_pkg::CTRL_W-1:0] next_rxc;

    // Transmit pins are sampled on our own clock
    xgr_sync #(.W(xgr_pkg::LINK_W)) u_tx_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({link.tx_clk, link.txc, link.txd}),
        .q       (tx_s)
    );

    assign link.rx_clk   = rclk;
    assign link.rxd      = rxd_q;
    assign link.rxc      = rxc_q;
    assign rx_word_ready = (div == DIV_HALF - 8'h01);

    always_comb begin
        next_tclk_prev     = tx_s[xgr_pkg::LINK_W-1];
        next_tx_word_valid = 1'b0;
        next_tx_word       = tx_word;
        next_tx_word_ctrl  = tx_word_ctrl;
        // Whole word taken on the transmit clock rising edge
        if (tx_s[xgr_pkg::LINK_W-1] && !tclk_prev) begin
            next_tx_word_valid = 1'b1;
            next_tx_word       = tx_s[xgr_pkg::DATA_W-1:0];
            next_tx_word_ctrl  = tx_s[xgr_pkg::LINK_W-2:xgr_pkg::DATA_W];
        end
    end

    always_comb begin
        next_div  = (div == DIV_LAST) ? 8'h00 : div + 8'h01;
        next_rclk = (next_div < DIV_HALF);
        next_rxd  = rxd_q;
        next_rxc  = rxc_q;
        // Idles fill any slot the user leaves empty
        if (rx_word_ready) begin
            next_rxd = rx_word_valid ? rx_word : xgr_pkg::IDLE_WORD;
            next_rxc = rx_word_valid ? rx_word_ctrl : xgr_pkg::IDLE_CTRL;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tclk_prev     <= 1'b0;
            tx_word_valid <= 1'b0;
            tx_word       <= '0;
            tx_word_ctrl  <= '0;
            div           <= 8'h00;
            rclk          <= 1'b0;
            rxd_q         <= xgr_pkg::IDLE_WORD;
            rxc_q         <= xgr_pkg::IDLE_CTRL;
        end else begin
            tclk_prev     <= next_tclk_prev;
            tx_word_valid <= next_tx_word_valid;
            tx_word       <= next_tx_word;
            tx_word_ctrl  <= next_tx_word_ctrl;
            div           <= next_div;
            rclk          <= next_rclk;
            rxd_q         <= next_rxd;
            rxc_q         <= next_rxc;
        end
    end
endmodule

// file: xgr_rs.sv
module xgr_rs #(
    parameter int DIV           = xgr_pkg::LINK_DIV,
    parameter int IPG_WORDS     = xgr_pkg::IPG_WORDS,
    parameter int LF_HOLD_WORDS = xgr_pkg::LF_HOLD_WORDS
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    xgr_if.rs               link,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_done,
    output logic            tx_ready,
    output logic            tx_busy,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_dv,
    output logic            rx_err,
    output logic            link_fail
);
    localparam logic [7:0]  DIV_LAST = 8'(DIV - 1);
    localparam logic [7:0]  DIV_HALF = 8'(DIV / 2);
    localparam logic [3:0]  IPG_INIT = 4'(IPG_WORDS);
    localparam logic [15:0] LF_INIT  = 16'(LF_HOLD_WORDS);
    localparam logic [3:0]  PRE_N    = 4'(xgr_pkg::PRE_OCTETS);
    localparam logic [3:0]  NULL_N   = 4'(xgr_pkg::NULL_OCTETS);

    xgr_pkg::xgr_tx_state_e tx_state;
    xgr_pkg::xgr_tx_state_e next_tx_state;
    logic [7:0]             div;
    logic [7:0]             next_div;
    logic                   tclk;
    logic                   next_tclk;
    logic [31:0]            asm_d;
    logic [31:0]            next_asm_d;
    logic [3:0]             asm_c;
    logic [3:0]             next_asm_c;
    logic [2:0]             lane;
    logic [2:0]             next_lane;
    logic [3:0]             oct;
    logic [3:0]             next_oct;
    logic [3:0]             ipg;
    logic [3:0]             next_ipg;
    logic [31:0]            txd_q;
    logic [31:0]            next_txd;
    logic [3:0]             txc_q;
    logic [3:0]             next_txc;
    logic                   slot;
    logic                   take;
    logic                   fin;

    // Link clock is made here from sys_clk; data moves on its falling edge
    assign link.tx_clk = tclk;
    assign link.txd    = txd_q;
    assign link.txc    = txc_q;
    assign slot        = (div == DIV_HALF - 8'h01);
    assign tx_ready    = (lane != 3'h4) && (tx_state != xgr_pkg::XGR_TX_IPG);
    assign take        = tx_valid && tx_ready;
    assign fin         = tx_done && tx_ready && tx_state == xgr_pkg::XGR_TX_DATA;
    assign tx_busy     = (tx_state != xgr_pkg::XGR_TX_IDLE);

    always_comb begin
        next_div      = (div == DIV_LAST) ? 8'h00 : div + 8'h01;
        next_tclk     = (next_div < DIV_HALF);
        next_tx_state = tx_state;
        next_asm_d    = asm_d;
        next_asm_c    = asm_c;
        next_lane     = lane;
        next_oct      = oct;
        next_ipg      = ipg;
        next_txd      = txd_q;
        next_txc      = txc_q;
        if (slot) begin
            if (lane == 3'h4) begin
                next_txd  = asm_d;
                next_txc  = asm_c;
                next_lane = 3'h0;
            end else begin
                // Idle word keeps the line busy every cycle
                next_txd = xgr_pkg::IDLE_WORD;
                next_txc = xgr_pkg::IDLE_CTRL;
                if (tx_state == xgr_pkg::XGR_TX_IPG) begin
                    if (ipg <= 4'h1) begin
                        next_tx_state = xgr_pkg::XGR_TX_IDLE;
                    end else begin
                        next_ipg = ipg - 4'h1;
                    end
                end
            end
        end
        case (tx_state)
            xgr_pkg::XGR_TX_IDLE: begin
                if (take && !tx_done) begin
                    // First octet becomes Start on lane 0
                    next_asm_d[7:0] = xgr_pkg::CH_START;
                    next_asm_c[0]   = 1'b1;
                    next_lane       = 3'h1;
                    next_oct        = 4'h1;
                    next_tx_state   = xgr_pkg::XGR_TX_DATA;
                end
            end
            xgr_pkg::XGR_TX_DATA: begin
                if (fin) begin
                    // Terminate, idles in later lanes, then own gap
                    next_asm_d[lane[1:0]*8 +: 8] = xgr_pkg::CH_TERM;
                    next_asm_c[lane[1:0]]        = 1'b1;
                    for (int i = 0; i < xgr_pkg::LANES; i++) begin
                        if (i > int'(lane)) begin
                            next_asm_d[i*8 +: 8] = xgr_pkg::CH_IDLE;
                            next_asm_c[i]        = 1'b1;
                        end
                    end
                    next_lane     = 3'h4;
                    next_ipg      = IPG_INIT;
                    next_tx_state = xgr_pkg::XGR_TX_IPG;
                end else if (take) begin
                    // Next lane in order, data bytes low to high
                    if (oct < PRE_N) begin
                        next_asm_d[lane[1:0]*8 +: 8] = xgr_pkg::CH_PRE;
                    end else if (oct == PRE_N) begin
                        next_asm_d[lane[1:0]*8 +: 8] = xgr_pkg::CH_SFD;
                    end else begin
                        next_asm_d[lane[1:0]*8 +: 8] = tx_data;
                    end
                    next_asm_c[lane[1:0]] = 1'b0;
                    next_lane             = lane + 3'h1;
                    next_oct              = (oct > PRE_N) ? oct : oct + 4'h1;
                end
            end
            xgr_pkg::XGR_TX_IPG: begin
                next_oct = 4'h0;
            end
            default: begin
                next_tx_state = xgr_pkg::XGR_TX_IDLE;
                next_lane     = 3'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= xgr_pkg::XGR_TX_IDLE;
            div      <= 8'h00;
            tclk     <= 1'b0;
            asm_d    <= 32'h0;
            asm_c    <= 4'h0;
            lane     <= 3'h0;
            oct      <= 4'h0;
            ipg      <= 4'h0;
            txd_q    <= xgr_pkg::IDLE_WORD;
            txc_q    <= xgr_pkg::IDLE_CTRL;
        end else begin
            tx_state <= next_tx_state;
            div      <= next_div;
            tclk     <= next_tclk;
            asm_d    <= next_asm_d;
            asm_c    <= next_asm_c;
            lane     <= next_lane;
            oct      <= next_oct;
            ipg      <= next_ipg;
            txd_q    <= next_txd;
            txc_q    <= next_txc;
        end
    end

    // Receive side: the far end owns the clock, no phase relation
    xgr_pkg::xgr_rx_state_e     rx_state;
    xgr_pkg::xgr_rx_state_e     next_rx_state;
    logic [xgr_pkg::LINK_W-1:0] rx_s;
    logic                       rclk_prev;
    logic [31:0]                w_d;
    logic [31:0]                next_w_d;
    logic [3:0]                 w_c;
    logic [3:0]                 next_w_c;
    logic [2:0]                 rl;
    logic [2:0]                 next_rl;
    logic                       prev_idle;
    logic                       next_prev_idle;
    logic [3:0]                 nul;
    logic [3:0]                 next_nul;
    logic [15:0]                lf_cnt;
    logic [15:0]                next_lf_cnt;
    logic                       next_link_fail;
    logic                       next_rx_valid;
    logic [7:0]                 next_rx_data;
    logic                       next_rx_dv;
    logic                       next_rx_err;
    logic [7:0]                 b;
    logic                       c;

    xgr_sync #(.W(xgr_pkg::LINK_W)) u_rx_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({link.rx_clk, link.rxc, link.rxd}),
        .q       (rx_s)
    );

    assign b = w_d[rl[1:0]*8 +: 8];
    assign c = w_c[rl[1:0]];

    always_comb begin
        next_rx_state  = rx_state;
        next_w_d       = w_d;
        next_w_c       = w_c;
        next_rl        = rl;
        next_prev_idle = prev_idle;
        next_nul       = nul;
        next_lf_cnt    = lf_cnt;
        next_link_fail = link_fail;
        next_rx_valid  = 1'b0;
        next_rx_data   = rx_data;
        next_rx_dv     = (rx_state == xgr_pkg::XGR_RX_IDLE) ? 1'b0 : rx_dv;
        next_rx_err    = 1'b0;
        if (rx_s[xgr_pkg::LINK_W-1] && !rclk_prev) begin
            // Word sampled on receive clock rise
            next_w_d       = rx_s[xgr_pkg::DATA_W-1:0];
            next_w_c       = rx_s[xgr_pkg::LINK_W-2:xgr_pkg::DATA_W];
            next_rl        = 3'h0;
            next_prev_idle = (w_c == xgr_pkg::IDLE_CTRL
                              && w_d == xgr_pkg::IDLE_WORD)
                             || (w_c == xgr_pkg::SEQ_CTRL
                                 && w_d[7:0] == xgr_pkg::CH_SEQ);
            // Local fault ordered set holds the fail flag
            if (next_w_c == xgr_pkg::SEQ_CTRL
                && next_w_d[7:0] == xgr_pkg::CH_SEQ
                && next_w_d[31:24] == xgr_pkg::LF_CODE) begin
                next_link_fail = 1'b1;
                next_lf_cnt    = LF_INIT;
            end else if (lf_cnt != 16'h0) begin
                next_lf_cnt = lf_cnt - 16'h1;
            end else begin
                next_link_fail = 1'b0;
            end
        end else if (rl != 3'h4) begin
            // One lane per cycle, lane 0 first
            next_rl = rl + 3'h1;
            case (rx_state)
                xgr_pkg::XGR_RX_IDLE: begin
                    if (rl == 3'h0 && c && b == xgr_pkg::CH_START
                        && prev_idle) begin
                        next_rx_state = xgr_pkg::XGR_RX_FRAME;
                        next_rx_valid = 1'b1;
                        next_rx_data  = xgr_pkg::NULL_OCT;
                        next_rx_dv    = 1'b1;
                        next_nul      = NULL_N;
                    end
                end
                xgr_pkg::XGR_RX_FRAME: begin
                    if (c && b == xgr_pkg::CH_TERM) begin
                        // No octet for Terminate
                        next_rx_state = xgr_pkg::XGR_RX_IDLE;
                        next_rx_dv    = 1'b0;
                        next_rl       = 3'h4;
                    end else if (c && b != xgr_pkg::CH_ERR) begin
                        // Flag the frame bad before valid drops
                        next_rx_state = xgr_pkg::XGR_RX_IDLE;
                        next_rx_valid = 1'b1;
                        next_rx_data  = b;
                        next_rx_err   = 1'b1;
                        next_rl       = 3'h4;
                    end else begin
                        next_rx_valid = 1'b1;
                        next_rx_err   = c;
                        next_rx_data  = (nul != 4'h0) ? xgr_pkg::NULL_OCT : b;
                        next_nul      = (nul != 4'h0) ? nul - 4'h1 : nul;
                    end
                end
                default: begin
                    next_rx_state = xgr_pkg::XGR_RX_IDLE;
                end
            endcase
        end
    end

    // The same logic serves an extender or a direct physical layer,
    // and stands in for the pins when used on-chip
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state  <= xgr_pkg::XGR_RX_IDLE;
            rclk_prev <= 1'b0;
            w_d       <= xgr_pkg::IDLE_WORD;
            w_c       <= xgr_pkg::IDLE_CTRL;
            rl        <= 3'h4;
            prev_idle <= 1'b0;
            nul       <= 4'h0;
            lf_cnt    <= 16'h0;
            link_fail <= 1'b0;
            rx_valid  <= 1'b0;
            rx_data   <= 8'h00;
            rx_dv     <= 1'b0;
            rx_err    <= 1'b0;
        end else begin
            rx_state  <= next_rx_state;
            rclk_prev <= rx_s[xgr_pkg::LINK_W-1];
            w_d       <= next_w_d;
            w_c       <= next_w_c;
            rl        <= next_rl;
            prev_idle <= next_prev_idle;
            nul       <= next_nul;
            lf_cnt    <= next_lf_cnt;
            link_fail <= next_link_fail;
            rx_valid  <= next_rx_valid;
            rx_data   <= next_rx_data;
            rx_dv     <= next_rx_dv;
            rx_err    <= next_rx_err;
        end
    end
endmodule

// file: xgr_sva.sv
module xgr_sva #(
    parameter int DIV = 16
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        tx_clk,
    input wire logic [31:0] txd,
    input wire logic [3:0]  txc,
    input wire logic        rx_clk,
    input wire logic [31:0] rxd,
    input wire logic [3:0]  rxc
);
    logic [7:0] tcnt, rcnt, next_tcnt, next_rcnt;
    logic       tprev, rprev, tseen, rseen, next_tseen, next_rseen;

    function automatic logic hit(input logic [31:0] d, input logic [3:0] c,
                                 input logic [7:0] ch);
        for (int i = 0; i < 4; i++) begin
            if (c[i] && d[8*i +: 8] == ch) return 1'b1;
        end
        return 1'b0;
    endfunction

    function automatic logic ctl_ok(input logic [31:0] d, input logic [3:0] c);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            b = d[8*i +: 8];
            if (c[i] && !(b inside {8'h07, 8'hFB, 8'hFD, 8'hFE, 8'h9C}))
                return 1'b0;
        end
        return 1'b1;
    endfunction

    // Period checks start after the first fall: the first high phase is short
    always_comb begin
        next_tcnt  = (tx_clk != tprev) ? 8'h00 : tcnt + 8'h01;
        next_rcnt  = (rx_clk != rprev) ? 8'h00 : rcnt + 8'h01;
        next_tseen = tseen | (tprev & ~tx_clk);
        next_rseen = rseen | (rprev & ~rx_clk);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {tcnt, rcnt, tprev, rprev, tseen, rseen} <= '0;
        end else begin
            {tcnt, rcnt, tprev, rprev, tseen, rseen} <=
                {next_tcnt, next_rcnt, tx_clk, rx_clk, next_tseen, next_rseen};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    tx_hold_a: assert property (
        ($changed(txd) || $changed(txc)) |-> $fell(tx_clk))
        else $error("txd or txc moved away from the falling link edge");
    rx_hold_a: assert property (
        ($changed(rxd) || $changed(rxc)) |-> $fell(rx_clk))
        else $error("rxd or rxc moved away from the falling link edge");
    tx_period_a: assert property (
        ($changed(tx_clk) && tseen) |-> tcnt == 8'(DIV/2-1))
        else $error("tx_clk half period wrong");
    rx_period_a: assert property (
        ($changed(rx_clk) && rseen) |-> rcnt == 8'(DIV/2-1))
        else $error("rx_clk half period wrong");
    ctrl_code_a: assert property (ctl_ok(txd, txc))
        else $error("control lane carries an unknown code");
    start_lane_a: assert property (
        hit(txd, txc, 8'hFB) |-> (txc == 4'h1 && txd[31:8] == 24'h555555))
        else $error("start word malformed");
    sfd_next_a: assert property (
        ($fell(tx_clk) && hit(txd, txc, 8'hFB))
        |-> ##16 (txd == 32'hD5555555 && txc == 4'h0))
        else $error("word after start is not preamble and delimiter");
    term_gap_a: assert property (
        ($fell(tx_clk) && hit(txd, txc, 8'hFD))
        |-> ##16 (txd == 32'h07070707 && txc == 4'hF))
        else $error("no idle word after terminate");

    cover property ($fell(tx_clk) && hit(txd, txc, 8'hFB));
    cover property ($fell(tx_clk) && hit(txd, txc, 8'hFD));
    cover property ($fell(rx_clk) && hit(rxd, rxc, 8'hFB));
    cover property ($fell(rx_clk) && rxc == 4'h1 && rxd == 32'h0100009C);
endmodule

// file: xgmii_reconciliation_lanes_bench.sv
module xgmii_reconciliation_lanes_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, rst_n = 1'b0;
    logic        tx_valid = 1'b0, tx_done = 1'b0, rx_word_valid = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    logic [31:0] rx_word = 32'h07070707;
    logic [3:0]  rx_word_ctrl = 4'hF;
    logic        tx_ready, tx_busy, rx_valid, rx_dv, rx_err, link_fail;
    logic        tx_word_valid, rx_word_ready;
    logic [7:0]  rx_data;
    logic [31:0] tx_word;
    logic [3:0]  tx_word_ctrl;
    int          n_mismatch = 0, tests_run = 0, cycles = 0, n_err = 0;
    logic [35:0] txq[$];
    logic [8:0]  rxq[$];
    logic [35:0] tx_exp[4] = '{36'h1555555FB, 36'h0D5555555, 36'h014131211,
                               36'hE0707FD15};
    logic [35:0] rx_w[9] = '{36'hF07070707, 36'h1555555FB, 36'h0D5555555,
                             36'h044332211, 36'hE07FDFE55, 36'h10100009C,
                             36'h1555555FB, 36'h0D5555555, 36'h207070766};

    always #2 sys_clk = ~sys_clk;

    xgr_if link();
    xgr_rs #(.LF_HOLD_WORDS(4)) i_xgr_rs (.sys_clk, .rst_n, .link(link.rs),
        .tx_valid, .tx_data, .tx_done, .tx_ready, .tx_busy, .rx_valid,
        .rx_data, .rx_dv, .rx_err, .link_fail);
    xgr_phy i_xgr_phy (.sys_clk, .rst_n, .link(link.phy), .tx_word_valid,
        .tx_word, .tx_word_ctrl, .rx_word_valid, .rx_word, .rx_word_ctrl,
        .rx_word_ready);
    xgr_sva #(.DIV(16)) i_xgr_sva (.sys_clk, .rst_n, .tx_clk(link.tx_clk),
        .txd(link.txd), .txc(link.txc), .rx_clk(link.rx_clk),
        .rxd(link.rxd), .rxc(link.rxc));

    task automatic fail(input string m);
        n_mismatch++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Request held until the edge that samples tx_ready high
    task automatic tx_put(input logic [7:0] b, input logic done);
        int n = 0;
        tx_valid <= !done;
        tx_done <= done;
        tx_data <= b;
        do begin @(posedge sys_clk); n++; end while (tx_ready !== 1'b1 && n < 64);
        if (n >= 64) fail("tx handshake stuck");
    endtask

    task automatic rx_put(input logic [35:0] w);
        int n = 0;
        rx_word_valid <= 1'b1;
        {rx_word_ctrl, rx_word} <= w;
        do begin @(posedge sys_clk); n++; end while (rx_word_ready !== 1'b1 && n < 64);
        if (n >= 64) fail("rx slot missing");
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n = 0;
        while (s !== v && n < lim) begin @(posedge sys_clk); n++; end
    endtask

    task automatic tx_test();
        for (int i = 0; i < 13; i++)
            tx_put(i < 7 ? 8'h55 : (i == 7 ? 8'hD5 : 8'(8'h11 + i - 8)), 1'b0);
        tx_put(8'h00, 1'b1);
        tx_valid <= 1'b0;
        tx_done <= 1'b0;
        chk({35'h0, tx_busy}, 36'h1);
        wait_for(tx_busy, 1'b0, 300);
        chk(36'(txq.size()), 36'h4);
        foreach (tx_exp[i]) chk(txq[i], tx_exp[i]);
        $display("tx frame test ended");
    endtask

    task automatic rx_test();
        logic [8:0] e;
        foreach (rx_w[i]) rx_put(rx_w[i]);
        rx_word_valid <= 1'b0;
        wait_for(link_fail, 1'b1, 64);
        chk({35'h0, link_fail}, 36'h1);
        wait_for(link_fail, 1'b0, 300);
        chk({35'h0, link_fail}, 36'h0);
        chk(36'(rxq.size()), 36'h18);
        // Second frame follows a sequence set and dies on an idle code
        for (int i = 0; i < 24; i++) begin
            e = (i < 9 || i > 13) ? 9'h100 : 9'(9'h122 + 9'h011 * (i - 9));
            if (i == 13) e = 9'h1FE;
            if (i == 23) e = 9'h107;
            chk({27'h0, rxq[i]}, {27'h0, e});
        end
        chk(36'(n_err), 36'h2);
        chk({35'h0, rx_dv}, 36'h0);
        $display("rx frame and fault test ended");
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail("timeout");
            test_done();
        end
        if (tx_word_valid === 1'b1 && {tx_word_ctrl, tx_word} !== 36'hF07070707)
            txq.push_back({tx_word_ctrl, tx_word});
        if (rx_valid === 1'b1) begin
            rxq.push_back({rx_dv, rx_data});
            if (rx_err === 1'b1) n_err++;
        end
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Receive side needs an idle or sequence word just before a start counts
        repeat (80) @(posedge sys_clk);
        fork
            tx_test();
            rx_test();
        join
        chk({link.txc, link.txd}, 36'hF07070707);
        test_done();
    end
endmodule
